/* afe_ctrl_bank.sv */
// Front-end control register bank behind the three-wire serial port
`timescale 1ns/1ns
module afe_ctrl_bank (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Serial port pins
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_load_n,
	// Vertical sync pin
	input wire logic vertical_sync,
	// Power and clamp controls
	output logic [1:0] power_mode,
	output logic black_clamp_on,
	output logic clamp_settle_fast,
	output logic gain_change_quick_clamp,
	output logic blanking_output_level,
	output logic dc_restore_off,
	output logic quick_clamp_pulse,
	// Output format controls
	output logic output_hiz,
	output logic output_latch_transparent,
	output logic gray_code_on,
	// Gains and clamp level
	output logic [2:0] sampler_gain_code,
	output logic [9:0] variable_gain_code,
	output logic [9:0] black_clamp_target,
	// Clock and sync controls
	output logic input_clock_halve,
	output logic sync_inputs_on
);

	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] ADDR_LAST = afe_pkg::ADDR_LAST;
	localparam logic [CNT_W-1:0] DATA_LAST = afe_pkg::DATA_LAST;

	// Input synchronisers
	logic [1:0] sck_sync_q;
	logic [1:0] sdi_sync_q;
	logic [1:0] sld_sync_q;
	logic [1:0] vs_sync_q;
	logic sck_prev_q;
	logic vs_prev_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sck_sync_q <= 2'h0;
			sdi_sync_q <= 2'h0;
			sld_sync_q <= 2'h3;
			vs_sync_q <= 2'h0;
		end else begin
			sck_sync_q <= {sck_sync_q[0], ser_clk};
			sdi_sync_q <= {sdi_sync_q[0], ser_data};
			sld_sync_q <= {sld_sync_q[0], ser_load_n};
			vs_sync_q <= {vs_sync_q[0], vertical_sync};
		end
	end

	// Edge detect history, after the second flop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sck_prev_q <= 1'b0;
			vs_prev_q <= 1'b0;
		end else begin
			sck_prev_q <= sck_sync_q[1];
			vs_prev_q <= vs_sync_q[1];
		end
	end

	// Edges of the synchronised pins, and the frame level from ser_load_n
	logic sck_rise;
	logic vs_fall;
	logic frame_on;
	assign sck_rise = sck_sync_q[1] & ~sck_prev_q;
	assign vs_fall = vs_prev_q & ~vs_sync_q[1];
	assign frame_on = ~sld_sync_q[1];

	// Serial shifter
	typedef enum logic {AFE_ADDR, AFE_DATA} afe_phase_t;
	afe_phase_t phase_q;
	logic [CNT_W-1:0] bit_cnt_q;
	logic [afe_pkg::ADDR_W-1:0] addr_q;
	logic [afe_pkg::DATA_W-1:0] shift_q;
	logic word_done;
	logic [afe_pkg::DATA_W-1:0] word_val;

	assign word_done = frame_on & sck_rise & (phase_q == AFE_DATA) & (bit_cnt_q == DATA_LAST);
	assign word_val = {ser_bit_in(sdi_sync_q[1]), shift_q[afe_pkg::DATA_W-1:1]};

	function automatic logic ser_bit_in(input logic b);
		ser_bit_in = b;
	endfunction : ser_bit_in

	// Address then data words, lsb first
	always_ff @(posedge clk) begin
		if (sys_rst || !frame_on) begin
			phase_q <= AFE_ADDR;
			bit_cnt_q <= '0;
			shift_q <= '0;
			if (sys_rst) begin
				addr_q <= '0;
			end
		end else if (sck_rise) begin
			case (phase_q)
				AFE_ADDR: begin
					addr_q <= {sdi_sync_q[1], addr_q[afe_pkg::ADDR_W-1:1]};
					if (bit_cnt_q == ADDR_LAST) begin
						phase_q <= AFE_DATA;
						bit_cnt_q <= '0;
					end else begin
						bit_cnt_q <= bit_cnt_q + 6'h01;
					end
				end
				AFE_DATA: begin
					shift_q <= word_val;
					if (bit_cnt_q == DATA_LAST) begin
						bit_cnt_q <= '0;
						addr_q <= addr_q + 12'h001;
					end else begin
						bit_cnt_q <= bit_cnt_q + 6'h01;
					end
				end
				default: begin
					phase_q <= AFE_ADDR;
				end
			endcase
		end
	end

	// Register storage, one live word per offset
	logic [afe_pkg::DATA_W-1:0] reg_word [afe_pkg::NUM_REGS];
	logic in_bank;
	assign in_bank = (addr_q[afe_pkg::ADDR_W-1:4] == 8'h00);

	function automatic logic [27:0] reset_val(input int idx);
		case (idx)
			0: reset_val = afe_pkg::RST_POWER_CLAMP;
			3: reset_val = afe_pkg::RST_TEST_B;
			5: reset_val = afe_pkg::RST_VARIABLE_GAIN;
			6: reset_val = afe_pkg::RST_CLAMP_LEVEL;
			default: reset_val = afe_pkg::RST_ZERO;
		endcase
	endfunction : reset_val

	function automatic logic [27:0] width_mask(input int idx);
		width_mask = 28'hfffffff >> (afe_pkg::DATA_W - afe_pkg::REG_WIDTH[idx]);
	endfunction : width_mask

	genvar gi;
	generate
		for (gi = 0; gi < afe_pkg::NUM_REGS; gi++) begin : g_reg
			logic hit;
			logic [afe_pkg::DATA_W-1:0] word_q;
			assign hit = word_done & in_bank & (addr_q[3:0] == 4'(gi));
			assign reg_word[gi] = word_q;
			if (afe_pkg::VSYNC_UPDATED[gi]) begin : g_vs
				logic [afe_pkg::DATA_W-1:0] pend_word_q;
				logic pend_q;
				// Pending copy, written by the serial port
				always_ff @(posedge clk) begin
					if (sys_rst) begin
						pend_word_q <= reset_val(gi);
					end else if (hit) begin
						pend_word_q <= word_val & width_mask(gi);
					end
				end
				// A write landing on the sync edge waits for the next one
				always_ff @(posedge clk) begin
					if (sys_rst) begin
						pend_q <= 1'b0;
					end else if (hit) begin
						pend_q <= 1'b1;
					end else if (vs_fall) begin
						pend_q <= 1'b0;
					end
				end
				// Live copy, loaded at the sync fall
				always_ff @(posedge clk) begin
					if (sys_rst) begin
						word_q <= reset_val(gi);
					end else if (vs_fall && pend_q) begin
						word_q <= pend_word_q;
					end
				end
			end else begin : g_sck
				always_ff @(posedge clk) begin
					if (sys_rst) begin
						word_q <= reset_val(gi);
					end else if (hit) begin
						word_q <= word_val & width_mask(gi);
					end
				end
			end
		end
	endgenerate

	// Words that feed the field outputs
	logic [afe_pkg::DATA_W-1:0] power_word;
	logic [afe_pkg::DATA_W-1:0] format_word;
	logic [afe_pkg::DATA_W-1:0] sampler_word;
	logic [afe_pkg::DATA_W-1:0] var_gain_word;
	logic [afe_pkg::DATA_W-1:0] level_word;
	logic [afe_pkg::DATA_W-1:0] halve_word;
	logic [afe_pkg::DATA_W-1:0] sync_word;
	assign power_word = reg_word[afe_pkg::OFS_POWER_CLAMP[3:0]];
	assign format_word = reg_word[afe_pkg::OFS_OUTPUT_FORMAT[3:0]];
	assign sampler_word = reg_word[afe_pkg::OFS_SAMPLER_GAIN[3:0]];
	assign var_gain_word = reg_word[afe_pkg::OFS_VARIABLE_GAIN[3:0]];
	assign level_word = reg_word[afe_pkg::OFS_CLAMP_LEVEL[3:0]];
	assign halve_word = reg_word[afe_pkg::OFS_CLOCK_DIV[3:0]];
	assign sync_word = reg_word[afe_pkg::OFS_SYNC_INPUT[3:0]];

	// Sampler gain change detect for quick clamp
	logic [2:0] gain_prev_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gain_prev_q <= afe_pkg::RST_ZERO[2:0];
		end else begin
			gain_prev_q <= sampler_word[2:0];
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			quick_clamp_pulse <= 1'b0;
		end else begin
			quick_clamp_pulse <= power_word[afe_pkg::POS_GAIN_QUICK_CLAMP]
				& (gain_prev_q != sampler_word[2:0]);
		end
	end

	// Power and clamp field outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			power_mode <= afe_pkg::RST_POWER_CLAMP[afe_pkg::POS_POWER_MODE +: 2];
			black_clamp_on <= afe_pkg::RST_POWER_CLAMP[afe_pkg::POS_BLACK_CLAMP_ON];
			clamp_settle_fast <= afe_pkg::RST_POWER_CLAMP[afe_pkg::POS_CLAMP_SETTLE_FAST];
			gain_change_quick_clamp <= afe_pkg::RST_POWER_CLAMP[afe_pkg::POS_GAIN_QUICK_CLAMP];
			blanking_output_level <= afe_pkg::RST_POWER_CLAMP[afe_pkg::POS_BLANK_LEVEL];
			dc_restore_off <= afe_pkg::RST_POWER_CLAMP[afe_pkg::POS_DC_RESTORE_OFF];
		end else begin
			power_mode <= power_word[afe_pkg::POS_POWER_MODE +: 2];
			black_clamp_on <= power_word[afe_pkg::POS_BLACK_CLAMP_ON];
			clamp_settle_fast <= power_word[afe_pkg::POS_CLAMP_SETTLE_FAST];
			gain_change_quick_clamp <= power_word[afe_pkg::POS_GAIN_QUICK_CLAMP];
			blanking_output_level <= power_word[afe_pkg::POS_BLANK_LEVEL];
			dc_restore_off <= power_word[afe_pkg::POS_DC_RESTORE_OFF];
		end
	end

	// Output format field outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			output_hiz <= afe_pkg::RST_ZERO[afe_pkg::POS_OUTPUT_HIZ];
			output_latch_transparent <= afe_pkg::RST_ZERO[afe_pkg::POS_LATCH_TRANSP];
			gray_code_on <= afe_pkg::RST_ZERO[afe_pkg::POS_GRAY_CODE_ON];
		end else begin
			output_hiz <= format_word[afe_pkg::POS_OUTPUT_HIZ];
			output_latch_transparent <= format_word[afe_pkg::POS_LATCH_TRANSP];
			gray_code_on <= format_word[afe_pkg::POS_GRAY_CODE_ON];
		end
	end

	// Gain and clamp level outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sampler_gain_code <= afe_pkg::RST_ZERO[2:0];
			variable_gain_code <= afe_pkg::RST_VARIABLE_GAIN[9:0];
			black_clamp_target <= afe_pkg::RST_CLAMP_LEVEL[9:0];
		end else begin
			sampler_gain_code <= sampler_word[2:0];
			variable_gain_code <= var_gain_word[9:0];
			black_clamp_target <= level_word[9:0];
		end
	end

	// Clock divider and sync input outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			input_clock_halve <= afe_pkg::RST_ZERO[afe_pkg::POS_CLOCK_HALVE];
			sync_inputs_on <= afe_pkg::RST_ZERO[afe_pkg::POS_SYNC_INPUTS_ON];
		end else begin
			input_clock_halve <= halve_word[afe_pkg::POS_CLOCK_HALVE];
			sync_inputs_on <= sync_word[afe_pkg::POS_SYNC_INPUTS_ON];
		end
	end

endmodule : afe_ctrl_bank

/* afe_pkg.sv */
// Register map, field positions and reset values of the front-end control bank
package afe_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 28;
	localparam int NUM_REGS = 16;
	// Last bit index of the address and of each data word
	localparam logic [5:0] ADDR_LAST = 6'h0b;
	localparam logic [5:0] DATA_LAST = 6'h1b;
	localparam logic [11:0] OFS_POWER_CLAMP = 12'h000;
	localparam logic [11:0] OFS_OUTPUT_FORMAT = 12'h001;
	localparam logic [11:0] OFS_TEST_A = 12'h002;
	localparam logic [11:0] OFS_TEST_B = 12'h003;
	localparam logic [11:0] OFS_SAMPLER_GAIN = 12'h004;
	localparam logic [11:0] OFS_VARIABLE_GAIN = 12'h005;
	localparam logic [11:0] OFS_CLAMP_LEVEL = 12'h006;
	localparam logic [11:0] OFS_TEST_C = 12'h007;
	localparam logic [11:0] OFS_TEST_D = 12'h008;
	localparam logic [11:0] OFS_TEST_E = 12'h009;
	localparam logic [11:0] OFS_TEST_F = 12'h00a;
	localparam logic [11:0] OFS_UNUSED = 12'h00b;
	localparam logic [11:0] OFS_TEST_G = 12'h00c;
	localparam logic [11:0] OFS_CLOCK_DIV = 12'h00d;
	localparam logic [11:0] OFS_SYNC_INPUT = 12'h00e;
	localparam logic [11:0] OFS_TEST_H = 12'h00f;
	// Field positions
	localparam int POS_POWER_MODE = 0;
	localparam int POS_BLACK_CLAMP_ON = 2;
	localparam int POS_CLAMP_SETTLE_FAST = 3;
	localparam int POS_GAIN_QUICK_CLAMP = 4;
	localparam int POS_BLANK_LEVEL = 5;
	localparam int POS_DC_RESTORE_OFF = 6;
	localparam int POS_OUTPUT_HIZ = 0;
	localparam int POS_LATCH_TRANSP = 1;
	localparam int POS_GRAY_CODE_ON = 2;
	localparam int POS_CLOCK_HALVE = 0;
	localparam int POS_SYNC_INPUTS_ON = 8;
	// Reset values
	localparam logic [27:0] RST_POWER_CLAMP = 28'h0000007;
	localparam logic [27:0] RST_TEST_B = 28'h0ffffff;
	localparam logic [27:0] RST_VARIABLE_GAIN = 28'h000000f;
	localparam logic [27:0] RST_CLAMP_LEVEL = 28'h00001ec;
	localparam logic [27:0] RST_ZERO = 28'h0000000;
	// Implemented width of each register, index by offset
	localparam int REG_WIDTH [16] = '{7, 4, 1, 24, 3, 10, 10, 28, 28, 28, 28, 28, 28, 8, 9, 28};
	// Sync-updated registers, bit per offset
	localparam logic [15:0] VSYNC_UPDATED = 16'ha7fc;
endpackage : afe_pkg

/* afe_ctrl_bank_props.sv */
// Checker for the front-end control bank outputs
`timescale 1ns/1ns
module afe_ctrl_props (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Pins
	input wire logic ser_load_n,
	input wire logic vertical_sync,
	// Controls
	input wire logic [1:0] power_mode,
	input wire logic black_clamp_on,
	input wire logic clamp_settle_fast,
	input wire logic gain_change_quick_clamp,
	input wire logic blanking_output_level,
	input wire logic dc_restore_off,
	input wire logic quick_clamp_pulse,
	input wire logic output_hiz,
	input wire logic output_latch_transparent,
	input wire logic gray_code_on,
	input wire logic [2:0] sampler_gain_code,
	input wire logic [9:0] variable_gain_code,
	input wire logic [9:0] black_clamp_target,
	input wire logic input_clock_halve,
	input wire logic sync_inputs_on
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [3:0] vd_q;
	logic [3:0] idle_q;
	// Cycles since sync fall and since frame end
	always_ff @(posedge clk) begin
		if (sys_rst) vd_q <= 4'hf;
		else if ($fell(vertical_sync)) vd_q <= 4'h0;
		else if (vd_q != 4'hf) vd_q <= vd_q + 4'h1;
	end
	always_ff @(posedge clk) begin
		if (sys_rst || !ser_load_n) idle_q <= 4'h0;
		else if (idle_q != 4'hf) idle_q <= idle_q + 4'h1;
	end
	reset_values_a: assert property ($fell(sys_rst) |-> power_mode == 2'h3 && black_clamp_on
		&& variable_gain_code == 10'h00f && black_clamp_target == 10'h1ec && !output_hiz)
		else $error("reset values wrong");
	vd_gain_a: assert property ($changed({sampler_gain_code, variable_gain_code})
		|-> vd_q inside {[2:7]}) else $error("gain changed off sync fall");
	vd_clamp_a: assert property ($changed({black_clamp_target, input_clock_halve})
		|-> vd_q inside {[2:7]}) else $error("clamp or divider changed off sync fall");
	imm_ctrl_a: assert property (idle_q > 4'ha |-> $stable({power_mode, black_clamp_on,
		clamp_settle_fast, gain_change_quick_clamp, blanking_output_level, dc_restore_off}))
		else $error("control changed without write");
	imm_fmt_a: assert property (idle_q > 4'ha |-> $stable({output_hiz,
		output_latch_transparent, gray_code_on, sync_inputs_on})) else $error("format changed");
	pulse_width_a: assert property (quick_clamp_pulse |=> !quick_clamp_pulse)
		else $error("quick clamp pulse too long");
	pulse_cause_a: assert property (quick_clamp_pulse |-> gain_change_quick_clamp
		&& sampler_gain_code != $past(sampler_gain_code, 2)) else $error("spurious quick clamp");
	pulse_effect_a: assert property ($changed(sampler_gain_code) && gain_change_quick_clamp
		|-> ##[0:1] quick_clamp_pulse) else $error("missing quick clamp");
	cover property (quick_clamp_pulse);
	cover property ($changed(black_clamp_target));
	cover property ($rose(sync_inputs_on));
endmodule : afe_ctrl_props

bind afe_ctrl_bank afe_ctrl_props chk_u (.*);

/* afe_host_model.sv */
// Host side of the three-wire serial port
`timescale 1ns/1ns
module afe_host_model (
	// Bench clock
	input wire logic clk,
	// Serial pins
	output logic ser_clk,
	output logic ser_data,
	output logic ser_load_n
);
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		ser_load_n = 1'b1;
	end
	// Address then n data bits, lsb first, 80 ns serial period
	task automatic frame(input logic [11:0] a, input logic [83:0] d, input int n);
		logic [95:0] bits;
		bits = {d, a};
		ser_load_n = 1'b0;
		for (int i = 0; i < 12 + n; i++) begin
			ser_data = bits[i];
			repeat (4) @(negedge clk);
			ser_clk = 1'b1;
			repeat (4) @(negedge clk);
			ser_clk = 1'b0;
		end
		ser_load_n = 1'b1;
		ser_data = ~ser_data;
		repeat (4) @(negedge clk);
	endtask : frame
endmodule : afe_host_model

/* afe_control_register_bank_bench.sv */
// Self-checking bench for the front-end control register bank
`timescale 1ns/1ns
module afe_control_register_bank_bench;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic vertical_sync = 1'b1;
	logic ser_clk, ser_data, ser_load_n, quick_clamp_pulse;
	logic [1:0] power_mode;
	logic black_clamp_on, clamp_settle_fast, gain_change_quick_clamp;
	logic blanking_output_level, dc_restore_off, output_hiz, gray_code_on;
	logic output_latch_transparent, input_clock_halve, sync_inputs_on;
	logic [2:0] sampler_gain_code;
	logic [9:0] variable_gain_code, black_clamp_target;
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	wire logic [6:0] r0 = {dc_restore_off, blanking_output_level, gain_change_quick_clamp,
		clamp_settle_fast, black_clamp_on, power_mode};
	wire logic [2:0] r1 = {gray_code_on, output_latch_transparent, output_hiz};
	wire logic [22:0] gains = {sampler_gain_code, variable_gain_code, black_clamp_target};
	afe_ctrl_bank dut_u (.*);
	afe_host_model host_u (.*);
	always #5 clk = ~clk;
	task automatic chk(input logic [22:0] e, input logic [22:0] g, input string nm);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic complete_run;
		if (fails == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			fails++;
			complete_run();
		end
	end
	task automatic vd_fall(output int np);
		np = 0;
		@(negedge clk) vertical_sync = 1'b0;
		for (int k = 0; k < 12; k++) begin
			if (k == 4) begin
				vertical_sync = 1'b1;
			end
			@(negedge clk);
			if (quick_clamp_pulse === 1'b1) begin
				np++;
			end
		end
	endtask : vd_fall
	task automatic t_reset;
		chk(23'h07, 23'(r0), "r0");
		chk(23'h0, {18'h0, r1, input_clock_halve, sync_inputs_on}, "r1");
		chk({3'h0, 10'h00f, 10'h1ec}, gains, "gains");
	endtask : t_reset
	task automatic t_imm;
		logic [6:0] w;
		for (int m = 0; m < 4; m++) begin
			w = {5'h1f - 5'(m), 2'(m)};
			host_u.frame(12'h000, 84'({28'(m + 4), 21'h0, w}), 56);
			repeat (8) @(negedge clk);
			chk(23'(w), 23'(r0), "r0");
			chk(23'(m + 4), 23'(r1), "r1");
		end
		host_u.frame(12'h00e, 84'h100, 28);
		repeat (8) @(negedge clk);
		chk(23'h1, 23'(sync_inputs_on), "sync_on");
	endtask : t_imm
	task automatic t_vd;
		logic [2:0] codes [4] = '{3'h4, 3'h6, 3'h7, 3'h0};
		logic [22:0] e;
		int np;
		e = {3'h0, 10'h00f, 10'h1ec};
		foreach (codes[i]) begin
			host_u.frame(12'h004, {18'h0, 10'h200 | codes[i], 18'h0, 10'h3f0 | codes[i],
				25'h0, codes[i]}, 84);
			repeat (8) @(negedge clk);
			chk(e, gains, "gains_held");
			vd_fall(np);
			chk(23'h1, 23'(np), "quick_clamp_pulse");
			e = {codes[i], 10'h3f0 | codes[i], 10'h200 | codes[i]};
			chk(e, gains, "gains");
		end
		host_u.frame(12'h005, 84'h2a, 20);
		host_u.frame(12'h00d, 84'h1, 28);
		vd_fall(np);
		chk(23'h0, 23'(np), "quick_clamp_idle");
		chk(e, gains, "short");
		chk(23'h1, 23'(input_clock_halve), "halve");
	endtask : t_vd
	task automatic t_rerst;
		@(negedge clk) sys_rst = 1'b1;
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		t_reset();
	endtask : t_rerst
	initial begin
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		t_reset();
		t_imm();
		t_vd();
		t_rerst();
		complete_run();
	end
endmodule : afe_control_register_bank_bench
